// File: design/pbc_defs.svh
// Constants for the Port B / Port C alternate function override block.
// Included only by the package; definitions only.
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

`define PBC_PINS 8
`define PBC_SYNC_DEPTH 2
`define PBC_CLK_PERIOD_NS 4
`define PBC_SPIKE_NS 50
// Shortest pulse that passes is one cycle longer than the spike limit
`define PBC_SPIKE_CYC \
    ((`PBC_SPIKE_NS + `PBC_CLK_PERIOD_NS - 1) / `PBC_CLK_PERIOD_NS)
`define PBC_SPIKE_CNT_W 5
`define PBC_BIT_CLKOUT 0
`define PBC_BIT_SS 2
`define PBC_BIT_MOSI 3
`define PBC_BIT_MISO 4
`define PBC_BIT_TWI_SDA 4
`define PBC_BIT_TWI_SCL 5
`define PBC_BIT_RESET 6

`endif

// File: design/pbc_override.sv
// Alternate function override for Port B bits 7..0 and Port C bits 6..3.
// Port bit logic and peripherals are on sys_clk; pads are asynchronous.
// Function
// - Programmed clock-output fuse drives divided clock on PB0
// - Divided clock output on PB0 stays active during reset
// - PB7 input enable override from RC, ext clock, async, pin change
// - PB6 pull-up, direction, input enable from RC and async select
// - MISO carries master in; slave out is PB4 value only as master, with PB4 forced input; MOSI master out/slave in
// - PB3 output value is SPI master out OR compare A OR tx
// - PB3 output value override on SPI master, compare A or tx; SPI master or tx sets pull/dir
// - PB2 input feeds pin change 2 and slave select; compare B out
// - PB0 output and direction overridden only by clock output fuse; input feeds pin change 0 and capture
// - PB5..0 input enable forced by pin change mask and group enable
// - Reset-disable fuse makes PC6 plain I/O, else reset input
// - PC6 as reset reads direction, output and input as zero
// - Two-wire enable makes PC5 open-drain slew-limited clock line
// - Two-wire enable makes PC4 open-drain slew-limited data line
// - Two-wire inputs ignore pulses shorter than 50 ns
// - PC3 is pin change 11, PC6..4 are pin change 14..12
// - USART rx forces PB4 input; pull-up follows output bit
// - USART tx forces PB3 to output
// - PB7 as clock pin reads direction, output and input as zero
`timescale 1ns/100ps
module pbc_override
    import pbc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] portb_out_reg,
    input wire logic [7:0] portb_dir_reg,
    input wire logic [7:0] portb_pcmsk,
    input wire logic [6:3] portc_out_reg,
    input wire logic [6:3] portc_dir_reg,
    input wire logic [6:3] portc_pcmsk,
    input wire logic pin_change_group0_enable,
    input wire logic pin_change_group1_enable,
    input wire logic global_pullup_disable,
    input wire logic internal_rc_selected,
    input wire logic external_clock_selected,
    input wire logic timer2_async_select,
    input wire logic clock_output_fuse,
    input wire logic reset_pin_disable_fuse,
    input wire logic divided_clock,
    input wire logic spi0_enable_bit,
    input wire logic spi_host_role_select,
    input wire logic spi0_sck_out,
    input wire logic spi0_master_out,
    input wire logic spi0_slave_out,
    input wire logic usart1_tx_enable,
    input wire logic usart1_rx_enable,
    input wire logic usart1_tx_data,
    input wire logic timer1_compare_a_en,
    input wire logic timer1_compare_a_out,
    input wire logic timer1_compare_b_en,
    input wire logic timer1_compare_b_out,
    input wire logic timer2_compare_a_en,
    input wire logic timer2_compare_a_out,
    input wire logic twowire_enable_bit,
    input wire logic twowire0_clock_drive_low,
    input wire logic twowire0_data_drive_low,
    input wire logic [7:0] portb_pad_in,
    input wire logic [6:3] portc_pad_in,
    output logic [7:0] portb_pad_out,
    output logic [7:0] portb_pad_oe_n,
    output logic [7:0] portb_pad_pullup,
    output logic [6:3] portc_pad_out,
    output logic [6:3] portc_pad_oe_n,
    output logic [6:3] portc_pad_pullup,
    output logic [5:4] portc_slew_limit,
    output logic [7:0] portb_pin_read,
    output logic [7:0] portb_dir_read,
    output logic [7:0] portb_out_read,
    output logic [6:3] portc_pin_read,
    output logic [6:3] portc_dir_read,
    output logic [6:3] portc_out_read,
    output logic [7:0] pin_change_group0_in,
    output logic [14:11] pin_change_group1_in,
    output logic timer1_capture_in,
    output logic spi0_slave_select,
    output logic spi0_master_in,
    output logic spi0_slave_in,
    output logic spi0_sck_in,
    output logic usart1_rx_data,
    output logic reset_pin_in,
    output logic twowire0_clock_line,
    output logic twowire0_data_line
);
    // Per-pin override signal set
    typedef struct packed {
        logic [7:0] pullup_override_enable;
        logic [7:0] pullup_override_value;
        logic [7:0] direction_override_enable;
        logic [7:0] direction_override_value;
        logic [7:0] output_value_override_enable;
        logic [7:0] output_value_override_value;
        logic [7:0] input_enable_override_enable;
        logic [7:0] input_enable_override_value;
    } pbc_ovr_t;

    typedef struct packed {
        logic [7:0] pb_in;
        logic [6:3] pc_in;
    } pbc_state_t;

    pbc_ovr_t ovb;
    pbc_ovr_t ovc;
    pbc_state_t state_reg;
    pbc_state_t state_next;
    logic [7:0] pb_sync;
    logic [6:3] pc_sync;
    logic scl_filt;
    logic sda_filt;
    logic [7:0] pb_ie;
    logic [6:3] pc_ie;
    logic spi_master;
    logic pb7_clock;
    logic pb6_clock;
    logic pc6_reset;

    // Shared override merge applied to every pin
    function automatic logic [2:0] pbc_merge(
        input logic pu_on, input logic pu_v,
        input logic dir_on, input logic dir_v,
        input logic out_on, input logic out_v,
        input logic port_out, input logic port_dir,
        input logic pu_off);
        logic dir;
        logic val;
        logic pu;
        dir = dir_on ? dir_v : port_dir;
        val = out_on ? out_v : port_out;
        pu = pu_on ? pu_v : (port_out & ~port_dir & ~pu_off);
        pbc_merge = {dir, val, pu};
    endfunction

    pbc_sync #(.WIDTH(8)) u_sync_b (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(portb_pad_in),
        .sync_out(pb_sync)
    );

    pbc_sync #(.WIDTH(4)) u_sync_c (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(portc_pad_in),
        .sync_out(pc_sync)
    );

    pbc_spike_filter u_filt_scl (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .line_in(pc_sync[`PBC_BIT_TWI_SCL]),
        .line_out(scl_filt)
    );

    pbc_spike_filter u_filt_sda (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .line_in(pc_sync[`PBC_BIT_TWI_SDA]),
        .line_out(sda_filt)
    );

    assign spi_master = spi0_enable_bit & spi_host_role_select;
    // crystal owns PB7 and PB6 in these modes
    assign pb7_clock = (internal_rc_selected & external_clock_selected)
        | timer2_async_select;
    assign pb6_clock = internal_rc_selected | timer2_async_select;
    assign pc6_reset = ~reset_pin_disable_fuse;

    always_comb begin
        ovb = '0;
        ovb.pullup_override_enable[7] = pb7_clock;
        ovb.direction_override_enable[7] = pb7_clock;
        ovb.input_enable_override_enable[7] = pb7_clock
            | (portb_pcmsk[7] & pin_change_group0_enable);
        ovb.input_enable_override_value[7] = (internal_rc_selected
            | external_clock_selected) & timer2_async_select;
        ovb.pullup_override_enable[6] = pb6_clock;
        ovb.direction_override_enable[6] = pb6_clock;
        ovb.input_enable_override_enable[6] = pb6_clock
            | (portb_pcmsk[6] & pin_change_group0_enable);
        ovb.input_enable_override_value[6] =
            internal_rc_selected & timer2_async_select;
        // SPI0 clock pin
        ovb.pullup_override_enable[5] = spi_master;
        ovb.pullup_override_value[5] =
            portb_out_reg[5] & ~global_pullup_disable;
        ovb.direction_override_enable[5] = spi_master;
        ovb.output_value_override_enable[5] = spi_master;
        ovb.output_value_override_value[5] = spi0_sck_out;
        // USART rx forces PB4 input, pull-up from output bit
        ovb.pullup_override_enable[4] = spi_master | usart1_rx_enable;
        ovb.pullup_override_value[4] =
            portb_out_reg[4] & ~global_pullup_disable;
        ovb.direction_override_enable[4] = spi_master | usart1_rx_enable;
        ovb.output_value_override_enable[4] = spi_master;
        ovb.output_value_override_value[4] = spi0_slave_out;
        ovb.pullup_override_enable[3] = spi_master | usart1_tx_enable;
        ovb.pullup_override_value[3] =
            portb_out_reg[3] & ~global_pullup_disable;
        ovb.direction_override_enable[3] = spi_master | usart1_tx_enable;
        ovb.direction_override_value[3] = usart1_tx_enable;
        ovb.output_value_override_enable[3] = spi_master
            | timer2_compare_a_en | usart1_tx_enable;
        ovb.output_value_override_value[3] = spi0_master_out
            | timer2_compare_a_out | usart1_tx_data;
        ovb.pullup_override_enable[2] = spi_master;
        ovb.pullup_override_value[2] =
            portb_out_reg[2] & ~global_pullup_disable;
        ovb.direction_override_enable[2] = spi_master;
        ovb.output_value_override_enable[2] = timer1_compare_b_en;
        ovb.output_value_override_value[2] = timer1_compare_b_out;
        // compare A needs software direction bit
        ovb.output_value_override_enable[1] = timer1_compare_a_en;
        ovb.output_value_override_value[1] = timer1_compare_a_out;
        // clock out on PB0 overrides port bits
        ovb.direction_override_enable[0] = clock_output_fuse;
        ovb.direction_override_value[0] = clock_output_fuse;
        ovb.output_value_override_enable[0] = clock_output_fuse;
        ovb.output_value_override_value[0] = divided_clock;
        for (int i = 0; i < 6; i++) begin
            ovb.input_enable_override_enable[i] =
                portb_pcmsk[i] & pin_change_group0_enable;
            ovb.input_enable_override_value[i] = 1'b1;
        end
    end

    always_comb begin
        ovc = '0;
        // PC6 reset pin when fuse unprogrammed
        ovc.pullup_override_enable[6] = pc6_reset;
        ovc.pullup_override_value[6] = 1'b1;
        ovc.direction_override_enable[6] = pc6_reset;
        ovc.input_enable_override_enable[6] = pc6_reset
            | (portc_pcmsk[6] & pin_change_group1_enable);
        ovc.input_enable_override_value[6] = ~pc6_reset;
        for (int i = 4; i < 6; i++) begin
            ovc.pullup_override_enable[i] = twowire_enable_bit;
            ovc.pullup_override_value[i] =
                portc_out_reg[i] & ~global_pullup_disable;
            ovc.direction_override_enable[i] = twowire_enable_bit;
            ovc.output_value_override_enable[i] = twowire_enable_bit;
            ovc.input_enable_override_enable[i] =
                portc_pcmsk[i] & pin_change_group1_enable;
            ovc.input_enable_override_value[i] = 1'b1;
        end
        ovc.direction_override_value[5] = twowire0_clock_drive_low;
        ovc.direction_override_value[4] = twowire0_data_drive_low;
        ovc.input_enable_override_enable[3] =
            portc_pcmsk[3] & pin_change_group1_enable;
        ovc.input_enable_override_value[3] = 1'b1;
    end

    always_comb begin
        logic [2:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            m = pbc_merge(ovb.pullup_override_enable[i],
                ovb.pullup_override_value[i],
                ovb.direction_override_enable[i],
                ovb.direction_override_value[i],
                ovb.output_value_override_enable[i],
                ovb.output_value_override_value[i],
                portb_out_reg[i], portb_dir_reg[i], global_pullup_disable);
            portb_pad_oe_n[i] = ~m[2];
            portb_pad_out[i] = m[1];
            portb_pad_pullup[i] = m[0] & ~m[2];
            pb_ie[i] = ovb.input_enable_override_enable[i]
                ? ovb.input_enable_override_value[i] : 1'b1;
        end
        for (int i = 3; i < 7; i++) begin
            m = pbc_merge(ovc.pullup_override_enable[i],
                ovc.pullup_override_value[i],
                ovc.direction_override_enable[i],
                ovc.direction_override_value[i],
                ovc.output_value_override_enable[i],
                ovc.output_value_override_value[i],
                portc_out_reg[i], portc_dir_reg[i], global_pullup_disable);
            portc_pad_oe_n[i] = ~m[2];
            portc_pad_out[i] = m[1];
            portc_pad_pullup[i] = m[0] & ~m[2];
            pc_ie[i] = ovc.input_enable_override_enable[i]
                ? ovc.input_enable_override_value[i] : 1'b1;
        end
    end

    always_comb begin
        state_next.pb_in = pb_sync & pb_ie;
        state_next.pc_in = pc_sync & pc_ie;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // slew limiting while two-wire owns the pins
    assign portc_slew_limit = {2{twowire_enable_bit}};

    // clock and reset pins read as zero
    always_comb begin
        portb_pin_read = state_reg.pb_in;
        portb_dir_read = portb_dir_reg;
        portb_out_read = portb_out_reg;
        portc_pin_read = state_reg.pc_in;
        portc_dir_read = portc_dir_reg;
        portc_out_read = portc_out_reg;
        if (pb7_clock) begin
            portb_pin_read[7] = 1'b0;
            portb_dir_read[7] = 1'b0;
            portb_out_read[7] = 1'b0;
        end
        if (pb6_clock) begin
            portb_pin_read[6] = 1'b0;
            portb_dir_read[6] = 1'b0;
            portb_out_read[6] = 1'b0;
        end
        if (pc6_reset) begin
            portc_pin_read[6] = 1'b0;
            portc_dir_read[6] = 1'b0;
            portc_out_read[6] = 1'b0;
        end
    end

    assign pin_change_group0_in = state_reg.pb_in;
    assign pin_change_group1_in = state_reg.pc_in;
    assign timer1_capture_in = state_reg.pb_in[0];
    // slave select is active low from the master
    assign spi0_slave_select = state_reg.pb_in[`PBC_BIT_SS];
    assign spi0_master_in = state_reg.pb_in[`PBC_BIT_MISO];
    assign spi0_slave_in = state_reg.pb_in[`PBC_BIT_MOSI];
    assign spi0_sck_in = state_reg.pb_in[5];
    assign usart1_rx_data = state_reg.pb_in[`PBC_BIT_MISO];
    assign reset_pin_in = pc6_reset & pc_sync[`PBC_BIT_RESET];
    assign twowire0_clock_line = scl_filt;
    assign twowire0_data_line = sda_filt;

    // PB0 follows divided clock even in reset
    clk_out_a: assert property (@(posedge sys_clk)
        clock_output_fuse |-> !portb_pad_oe_n[0]
        && portb_pad_out[0] == divided_clock)
        else $error("divided clock not on PB0");
    mosi_or_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (spi_master || timer2_compare_a_en || usart1_tx_enable) |->
        portb_pad_out[3] == (spi0_master_out | timer2_compare_a_out
        | usart1_tx_data))
        else $error("PB3 override value wrong");
    tx_output_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        usart1_tx_enable |-> !portb_pad_oe_n[3])
        else $error("PB3 not output with tx enabled");
    rx_input_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        usart1_rx_enable |-> portb_pad_oe_n[4]
        && portb_pad_pullup[4] == (portb_out_reg[4]
        & ~global_pullup_disable))
        else $error("PB4 not input with rx enabled");
    reset_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pc6_reset |-> portc_pin_read[6] == 1'b0
        && portc_dir_read[6] == 1'b0 && portc_pad_oe_n[6])
        else $error("PC6 reset pin not reading zero");
    clock_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pb7_clock |-> portb_dir_read[7] == 1'b0
        && portb_out_read[7] == 1'b0 && portb_pin_read[7] == 1'b0)
        else $error("PB7 clock pin not reading zero");
    twi_od_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        twowire_enable_bit |-> portc_pad_out[5:4] == 2'h0
        && portc_slew_limit == 2'h3)
        else $error("two-wire pins not open-drain");
    pc_ie_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (portb_pcmsk[1] && pin_change_group0_enable) |=>
        pin_change_group0_in[1] == $past(pb_sync[1]))
        else $error("pin change input not enabled");
endmodule

// File: design/pbc_pkg.sv
// Types shared by the override block and its helpers.
// Assumes pbc_defs.svh is on the include path.
`include "pbc_defs.svh"
package pbc_pkg;
    typedef logic [`PBC_PINS-1:0] pbc_byte_t;
    typedef logic [`PBC_SPIKE_CNT_W-1:0] pbc_cnt_t;
    typedef enum logic [1:0] {
        PBC_FILT_LOW = 2'b01,
        PBC_FILT_HIGH = 2'b10
    } pbc_filt_state_t;
endpackage

// File: design/pbc_spike_filter.sv
// Spike filter for one synchronised two-wire line.
// Input already synchronised; output moves only after a stable run.
`timescale 1ns/100ps
module pbc_spike_filter
    import pbc_pkg::*;
#(
    parameter int STABLE_CYC = `PBC_SPIKE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic line_in,
    output logic line_out
);
    typedef struct packed {
        pbc_filt_state_t fsm;
        pbc_cnt_t cnt;
    } pbc_filt_t;

    pbc_filt_t state_reg;
    pbc_filt_t state_next;

    // Idle bus is high, so start high to avoid a false edge
    always_comb begin
        state_next = state_reg;
        case (state_reg.fsm)
            PBC_FILT_LOW: begin
                if (!line_in) begin
                    state_next.cnt = '0;
                end else if (state_reg.cnt >= pbc_cnt_t'(STABLE_CYC)) begin
                    state_next.fsm = PBC_FILT_HIGH;
                    state_next.cnt = '0;
                end else begin
                    state_next.cnt = state_reg.cnt + pbc_cnt_t'(1);
                end
            end
            PBC_FILT_HIGH: begin
                if (line_in) begin
                    state_next.cnt = '0;
                end else if (state_reg.cnt >= pbc_cnt_t'(STABLE_CYC)) begin
                    state_next.fsm = PBC_FILT_LOW;
                    state_next.cnt = '0;
                end else begin
                    state_next.cnt = state_reg.cnt + pbc_cnt_t'(1);
                end
            end
            default: begin
                state_next.fsm = PBC_FILT_HIGH;
                state_next.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg.fsm <= PBC_FILT_HIGH;
            state_reg.cnt <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign line_out = (state_reg.fsm == PBC_FILT_HIGH);

    // Output flips only to the level line_in had on the previous sample
    spike_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(line_out) |-> $past(line_in) == line_out)
        else $error("filter output changed against its input");
endmodule

// File: design/pbc_sync.sv
// Two-flop synchroniser for a vector of pad inputs.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/100ps
module pbc_sync
    import pbc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pbc_sync_state_t;

    pbc_sync_state_t state_reg;
    pbc_sync_state_t state_next;

    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule

// File: test/pbc_periph_model.sv
// Stand-in for the timers, SPI, USART and clock divider feeding PB.
// Assumes one sys_clk; outputs move by non-blocking assignment.
`timescale 1ns/100ps
module pbc_periph_model (
    input wire logic sys_clk,
    output logic divided_clock,
    output logic spi0_sck_out,
    output logic spi0_master_out,
    output logic spi0_slave_out,
    output logic usart1_tx_data,
    output logic timer1_compare_a_out,
    output logic timer1_compare_b_out,
    output logic timer2_compare_a_out
);
    logic [7:0] pbc_cnt_reg = 8'h00;
    always_ff @(posedge sys_clk) begin
        pbc_cnt_reg <= pbc_cnt_reg + 8'h01;
    end
    assign divided_clock = pbc_cnt_reg[0];
    assign {spi0_sck_out, spi0_master_out} = pbc_cnt_reg[2:1];
    assign {spi0_slave_out, usart1_tx_data} = pbc_cnt_reg[4:3];
    assign {timer1_compare_a_out, timer1_compare_b_out} = pbc_cnt_reg[6:5];
    assign timer2_compare_a_out = pbc_cnt_reg[7];
endmodule

// File: test/port_b_c_alt_function_override_tb_top.sv
// Self-checking bench for the port B/C override block.
// Peripheral outputs come from pbc_periph_model.
`timescale 1ns/100ps
module port_b_c_alt_function_override_tb_top;
    logic sys_clk = 1'b0, sys_rst = 1'b1;
    logic [7:0] portb_out_reg = 8'h00, portb_dir_reg = 8'h00;
    logic [7:0] portb_pcmsk = 8'h00, portb_pad_in = 8'h00;
    logic [6:3] portc_out_reg = 4'h0, portc_dir_reg = 4'h0;
    logic [6:3] portc_pcmsk = 4'h0, portc_pad_in = 4'h0;
    logic pin_change_group0_enable = 1'b0, pin_change_group1_enable = 1'b0;
    logic global_pullup_disable = 1'b0, internal_rc_selected = 1'b0;
    logic external_clock_selected = 1'b0, timer2_async_select = 1'b0;
    logic clock_output_fuse = 1'b0, reset_pin_disable_fuse = 1'b1;
    logic spi0_enable_bit = 1'b0, spi_host_role_select = 1'b0;
    logic usart1_tx_enable = 1'b0, usart1_rx_enable = 1'b0;
    logic timer1_compare_a_en = 1'b0, timer1_compare_b_en = 1'b0;
    logic timer2_compare_a_en = 1'b0, twowire_enable_bit = 1'b0;
    logic twowire0_clock_drive_low = 1'b0, twowire0_data_drive_low = 1'b0;
    logic divided_clock, spi0_sck_out, spi0_master_out, spi0_slave_out;
    logic usart1_tx_data, timer1_compare_a_out, timer1_compare_b_out;
    logic timer2_compare_a_out, timer1_capture_in, spi0_slave_select;
    logic spi0_master_in, spi0_slave_in, spi0_sck_in, usart1_rx_data;
    logic reset_pin_in, twowire0_clock_line, twowire0_data_line;
    logic [7:0] portb_pad_out, portb_pad_oe_n, portb_pad_pullup;
    logic [7:0] portb_pin_read, portb_dir_read, portb_out_read;
    logic [7:0] pin_change_group0_in;
    logic [6:3] portc_pad_out, portc_pad_oe_n, portc_pad_pullup;
    logic [6:3] portc_pin_read, portc_dir_read, portc_out_read;
    logic [5:4] portc_slew_limit;
    logic [14:11] pin_change_group1_in;
    int failures = 0, compares = 0;

    pbc_override dut (.*);
    pbc_periph_model far_side (.*);

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_clkout();
        clock_output_fuse = 1'b1;
        cyc(1);
        chk(8'(portb_pad_out[0]), 8'(divided_clock));
        chk(8'(portb_pad_oe_n[0]), 8'h00);
        sys_rst = 1'b1;
        cyc(2);
        chk(8'(portb_pad_out[0]), 8'(divided_clock));
        sys_rst = 1'b0;
        clock_output_fuse = 1'b0;
        $display("t_clkout done");
    endtask

    task automatic t_pb13();
        portb_dir_reg = 8'h02;
        timer1_compare_a_en = 1'b1;
        timer2_compare_a_en = 1'b1;
        usart1_tx_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            chk(8'(portb_pad_out[1]), 8'(timer1_compare_a_out));
            chk(8'(portb_pad_oe_n[3]), 8'h00);
            chk(8'(portb_pad_out[3]), 8'(spi0_master_out | timer2_compare_a_out
                | usart1_tx_data));
        end
        chk(8'(portb_pad_oe_n[1]), 8'h00);
        timer1_compare_a_en = 1'b0;
        portb_out_reg = 8'h02;
        cyc(1);
        chk(8'(portb_pad_out[1]), 8'h01);
        {timer2_compare_a_en, usart1_tx_enable, portb_dir_reg} = 10'h000;
        portb_out_reg = 8'h00;
        cyc(1);
        chk(8'(portb_pad_oe_n[3]), 8'h01);
        $display("t_pb13 done");
    endtask

    task automatic t_pb20();
        {portb_pcmsk, pin_change_group0_enable} = {8'h07, 1'b1};
        {portb_pad_in, portb_dir_reg} = 16'h0704;
        timer1_compare_b_en = 1'b1;
        cyc(4);
        chk(8'(spi0_slave_select), 8'h01);
        chk(8'(timer1_capture_in), 8'h01);
        chk(pin_change_group0_in, 8'h07);
        chk(8'(portb_pad_out[2]), 8'(timer1_compare_b_out));
        portb_pad_in = 8'h00;
        cyc(4);
        chk(8'(spi0_slave_select), 8'h00);
        chk(8'(portb_pad_oe_n[0]), 8'h01);
        {portb_pcmsk, pin_change_group0_enable} = 9'h000;
        {portb_dir_reg, timer1_compare_b_en} = 9'h000;
        $display("t_pb20 done");
    endtask

    task automatic t_pb4();
        {portb_dir_reg, portb_out_reg, portb_pad_in} = 24'h101038;
        {usart1_rx_enable, spi0_enable_bit, spi_host_role_select} = 3'h7;
        cyc(4);
        chk(8'(portb_pad_oe_n[4]), 8'h01);
        chk(8'(portb_pad_pullup[4]), 8'h01);
        chk(8'(usart1_rx_data), 8'h01);
        chk(8'({spi0_sck_in, spi0_master_in, spi0_slave_in}), 8'h07);
        chk(8'(portb_pad_out[5]), 8'(spi0_sck_out));
        {portb_dir_reg, portb_out_reg, portb_pad_in} = 24'h000000;
        {usart1_rx_enable, spi0_enable_bit, spi_host_role_select} = 3'h0;
        $display("t_pb4 done");
    endtask

    task automatic t_pb7();
        {portb_dir_reg, portb_out_reg, portb_pad_in} = {8'hC0, 8'hC0, 8'hC0};
        for (int i = 5; i < 7; i++) begin
            {internal_rc_selected, external_clock_selected,
                timer2_async_select} = 3'(i);
            cyc(4);
            chk(portb_dir_read & 8'hC0, 8'h00);
            chk(portb_out_read & 8'hC0, 8'h00);
            chk(portb_pin_read & 8'hC0, 8'h00);
            chk(portb_pad_oe_n & 8'hC0, 8'hC0);
        end
        {internal_rc_selected, external_clock_selected,
            timer2_async_select} = 3'h0;
        {portb_dir_reg, portb_out_reg, portb_pad_in} = 24'h000000;
        $display("t_pb7 done");
    endtask

    task automatic t_pc6();
        {portc_dir_reg, portc_out_reg, portc_pad_in} = 12'h889;
        {portc_pcmsk, pin_change_group1_enable} = 5'h1F;
        reset_pin_disable_fuse = 1'b0;
        cyc(4);
        chk(8'({portc_dir_read[6], portc_out_read[6]}), 8'h00);
        chk(8'(portc_pin_read[6]), 8'h00);
        chk(8'(reset_pin_in), 8'h01);
        chk(8'(portc_pad_pullup[6]), 8'h01);
        chk(8'(pin_change_group1_in), 8'h01);
        reset_pin_disable_fuse = 1'b1;
        cyc(4);
        chk(8'({portc_dir_read[6], portc_out_read[6], portc_pin_read[6]}),
            8'h07);
        chk(8'(pin_change_group1_in), 8'h09);
        {portc_pcmsk, pin_change_group1_enable} = 5'h00;
        {portc_dir_reg, portc_out_reg} = 8'h00;
        $display("t_pc6 done");
    endtask

    task automatic t_twi();
        int n;
        {twowire_enable_bit, portc_pad_in} = 5'h16;
        cyc(24);
        chk(8'(portc_slew_limit), 8'h03);
        chk(8'({twowire0_clock_line, twowire0_data_line}), 8'h03);
        {twowire0_clock_drive_low, twowire0_data_drive_low} = 2'b11;
        cyc(1);
        chk(8'(portc_pad_oe_n[5:4]), 8'h00);
        {twowire0_clock_drive_low, twowire0_data_drive_low} = 2'b00;
        portc_pad_in = 4'h2;
        cyc(12);
        portc_pad_in = 4'h6;
        repeat (20) begin
            cyc(1);
            chk(8'(twowire0_clock_line), 8'h01);
        end
        portc_pad_in = 4'h2;
        n = 0;
        while (twowire0_clock_line !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(8'(n > 12 && n < 40), 8'h01);
        if (n >= 40) end_sim();
        {twowire_enable_bit, portc_pad_in} = 5'h00;
        $display("t_twi done");
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        t_clkout();
        t_pb13();
        t_pb20();
        t_pb4();
        t_pb7();
        t_pc6();
        t_twi();
        end_sim();
    end
endmodule
